// File: hdl/cdp_pkg.sv
// constants and carriers for the diagnostic/performance coprocessor register bank
// assumes a single core clock and coprocessor move access by register number and sub-code
package cdp_pkg;
  localparam logic [4:0] CDP_REG_BADPA = 5'h17;
  localparam logic [4:0] CDP_REG_BRK = 5'h18;
  localparam logic [4:0] CDP_REG_PERF = 5'h19;
  localparam logic [4:0] CDP_REG_STAGE_LO = 5'h1C;
  localparam logic [4:0] CDP_REG_STAGE_HI = 5'h1D;
  localparam logic [4:0] CDP_REG_RESUME = 5'h1E;
  localparam logic [2:0] CDP_BRK_CTRL = 3'h0;
  localparam logic [2:0] CDP_BRK_IADDR = 3'h2;
  localparam logic [2:0] CDP_BRK_IMASK = 3'h3;
  localparam logic [2:0] CDP_BRK_DADDR = 3'h4;
  localparam logic [2:0] CDP_BRK_DAMASK = 3'h5;
  localparam logic [2:0] CDP_BRK_DVAL = 3'h6;
  localparam logic [2:0] CDP_BRK_DVMASK = 3'h7;
  localparam logic [1:0] CDP_PERF_CTRL = 2'h0;
  localparam logic [1:0] CDP_PERF_CNT0 = 2'h1;
  localparam logic [1:0] CDP_PERF_CNT1 = 2'h3;
  localparam int CDP_CTL_GLOBAL_EN = 31;
  localparam int CDP_CTL_EV1_LSB = 15;
  localparam int CDP_CTL_EV0_LSB = 5;
  localparam int CDP_CTL_CNT1_BASE = 11;
  localparam int CDP_CTL_CNT0_BASE = 1;
  localparam logic [31:0] CDP_CTL_WMASK = 32'h800FFBFE;
  localparam logic [31:0] CDP_BADPA_MASK = 32'hFFFFFFF0;
  localparam logic [4:0] CDP_EV_NONE = 5'h10;
  localparam logic [4:0] CDP_EV_CYCLE = 5'h01;
  localparam logic [31:0] CDP_RESET_WORD = 32'h00000000;
  localparam logic [1:0] CDP_MODE_KERNEL = 2'h0;
  localparam logic [1:0] CDP_MODE_SUPER = 2'h1;
  localparam logic [1:0] CDP_MODE_USER = 2'h2;

  typedef struct packed {
    logic wr;
    logic [4:0] num;
    logic [2:0] sub;
    logic [31:0] wdata;
  } cdp_move_s;

  typedef struct packed {
    logic take;
    logic in_delay_slot;
    logic [31:0] pc;
    logic [31:0] branch_pc;
  } cdp_l2exc_s;

  typedef struct packed {
    logic load;
    logic [31:0] lo;
    logic [31:0] hi;
  } cdp_tagload_s;
endpackage : cdp_pkg

// File: hdl/cdp_regs.sv
// diagnostic, breakpoint, event-counter, cache-staging and resume-address registers
// assumes core-side inputs are synchronous to ref_clk; reads are combinational on move inputs
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module cdp_regs
  import cdp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // coprocessor move port
  input wire cdp_move_s move,
  output logic [31:0] move_rdata,
  // bus error reporting
  input wire logic bus_error,
  input wire logic [31:0] bus_error_paddr,
  input wire logic bus_error_mask,
  // processor mode and events
  input wire logic [1:0] cpu_mode,
  input wire logic first_level_exception_flag,
  input wire logic [15:0] counter_zero_events,
  input wire logic [15:0] counter_one_events,
  // second-level exception entry and cache reads
  input wire cdp_l2exc_s l2exc,
  input wire cdp_tagload_s tag_load,
  // outputs to core
  output logic second_level_delay_slot_flag,
  output logic counter_exception_req,
  output logic [31:0] cache_tag_stage_low,
  output logic [31:0] cache_tag_stage_high,
  output logic [31:0] breakpoint_control,
  output logic [31:0] second_level_resume_address
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [31:0] badpa_reg;
  logic [31:0] brk_reg [8];
  logic [31:0] ctl_reg;
  logic [31:0] cnt_reg [2];
  logic [31:0] stage_lo_reg;
  logic [31:0] stage_hi_reg;
  logic [31:0] resume_reg;
  logic slot_reg;
  logic exc_reg;
  logic [1:0] carry;
  logic [1:0] count_en;
  logic [1:0] ctr_hit;

  wire logic wr_brk = move.wr && move.num == CDP_REG_BRK;
  wire logic wr_perf = move.wr && move.num == CDP_REG_PERF;

  ////////////////////////////////////////////////////////////////////////////
  // bus-error address
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      badpa_reg <= CDP_RESET_WORD;
    else if (bus_error && !bus_error_mask)
      badpa_reg <= bus_error_paddr & CDP_BADPA_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // breakpoint bank; slot 1 is reset to zero, never written, and reads zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_brk
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          brk_reg[gi] <= CDP_RESET_WORD;
        else if (gi != 1 && wr_brk && move.sub == 3'(gi))
          brk_reg[gi] <= move.wdata;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // counter control
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ctl_reg <= CDP_RESET_WORD;
    else if (wr_perf && move.sub[1:0] == CDP_PERF_CTRL)
      ctl_reg <= move.wdata & CDP_CTL_WMASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // event counters, one per generate entry
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cnt
      localparam int BASE = gi ? CDP_CTL_CNT1_BASE : CDP_CTL_CNT0_BASE;
      localparam int EVL = gi ? CDP_CTL_EV1_LSB : CDP_CTL_EV0_LSB;
      logic [4:0] sel;
      logic [15:0] evs;
      logic mode_ok;
      logic [31:0] inc;
      assign sel = ctl_reg[EVL +: 5];
      assign evs = gi ? counter_one_events : counter_zero_events;
      // sel of 16 or above is no event or reserved, so never counts
      assign ctr_hit[gi] = !sel[4] && evs[sel[3:0]];
      always_comb
      begin
        if (first_level_exception_flag)
          mode_ok = ctl_reg[BASE];
        else if (cpu_mode == CDP_MODE_USER)
          mode_ok = ctl_reg[BASE + 3];
        else if (cpu_mode == CDP_MODE_SUPER)
          mode_ok = ctl_reg[BASE + 2];
        else
          mode_ok = ctl_reg[BASE + 1];
      end
      assign count_en[gi] = ctl_reg[CDP_CTL_GLOBAL_EN] && mode_ok && ctr_hit[gi];
      assign inc = {1'b0, cnt_reg[gi][30:0]} + 32'h00000001;
      assign carry[gi] = count_en[gi] && inc[31];
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          cnt_reg[gi] <= CDP_RESET_WORD;
        else if (wr_perf && move.sub[1:0] == (gi ? CDP_PERF_CNT1 : CDP_PERF_CNT0))
          cnt_reg[gi] <= move.wdata;
        else if (count_en[gi])
          cnt_reg[gi] <= {cnt_reg[gi][31] | inc[31], inc[30:0]};
      end
    end
  endgenerate

  // counter exception only while globally enabled
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      exc_reg <= 1'b0;
    else
      exc_reg <= ctl_reg[CDP_CTL_GLOBAL_EN] && (|carry);
  end

  ////////////////////////////////////////////////////////////////////////////
  // cache staging; cache read-back wins over a same-cycle move write
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage_lo_reg <= CDP_RESET_WORD;
      stage_hi_reg <= CDP_RESET_WORD;
    end
    else if (tag_load.load)
    begin
      stage_lo_reg <= tag_load.lo;
      stage_hi_reg <= tag_load.hi;
    end
    else if (move.wr && move.num == CDP_REG_STAGE_LO)
      stage_lo_reg <= move.wdata;
    else if (move.wr && move.num == CDP_REG_STAGE_HI)
      stage_hi_reg <= move.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // second-level resume address; exception entry beats software write
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      resume_reg <= CDP_RESET_WORD;
      slot_reg <= 1'b0;
    end
    else if (l2exc.take)
    begin
      slot_reg <= l2exc.in_delay_slot;
      resume_reg <= l2exc.in_delay_slot ? l2exc.branch_pc : l2exc.pc;
    end
    else if (move.wr && move.num == CDP_REG_RESUME)
      resume_reg <= move.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb
  begin
    move_rdata = CDP_RESET_WORD;
    case (move.num)
      CDP_REG_BADPA: move_rdata = badpa_reg;
      CDP_REG_BRK: move_rdata = brk_reg[move.sub];
      CDP_REG_PERF:
        case (move.sub[1:0])
          CDP_PERF_CTRL: move_rdata = ctl_reg;
          CDP_PERF_CNT0: move_rdata = cnt_reg[0];
          CDP_PERF_CNT1: move_rdata = cnt_reg[1];
          default: move_rdata = CDP_RESET_WORD;
        endcase
      CDP_REG_STAGE_LO: move_rdata = stage_lo_reg;
      CDP_REG_STAGE_HI: move_rdata = stage_hi_reg;
      CDP_REG_RESUME: move_rdata = resume_reg;
      default: move_rdata = CDP_RESET_WORD;
    endcase
  end

  // staging words go straight to the cache; the cache side picks fields per operation
  assign cache_tag_stage_low = stage_lo_reg;
  assign cache_tag_stage_high = stage_hi_reg;
  assign breakpoint_control = brk_reg[CDP_BRK_CTRL];
  assign second_level_resume_address = resume_reg;
  assign second_level_delay_slot_flag = slot_reg;
  assign counter_exception_req = exc_reg;

endmodule : cdp_regs

// File: testbench/cdp_regs_sva.sv
// port assertions for cdp_regs
// assumes one core clock and the async active-low reset nrst
`timescale 1ns/1ns
module cdp_regs_sva
  import cdp_pkg::*;
(
  // clock, reset and move port
  input wire logic ref_clk,
  input wire logic nrst,
  input wire cdp_move_s move,
  input wire logic [31:0] move_rdata,
  // core side inputs
  input wire logic bus_error,
  input wire logic [31:0] bus_error_paddr,
  input wire logic bus_error_mask,
  input wire cdp_l2exc_s l2exc,
  input wire cdp_tagload_s tag_load,
  // registered outputs
  input wire logic second_level_delay_slot_flag,
  input wire logic [31:0] cache_tag_stage_low,
  input wire logic [31:0] cache_tag_stage_high,
  input wire logic [31:0] breakpoint_control,
  input wire logic [31:0] second_level_resume_address
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // shadow of the captured bus-error address, reset value taken as zero
  logic [31:0] badpa_reg;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      badpa_reg <= 32'h0;
    else if (bus_error && !bus_error_mask)
      badpa_reg <= bus_error_paddr & CDP_BADPA_MASK;
  sequence l2_take;
    l2exc.take;
  endsequence
  a_resume_capture: assert property (l2_take |=> second_level_resume_address ==
    ($past(l2exc.in_delay_slot) ? $past(l2exc.branch_pc) : $past(l2exc.pc)))
    else $error("resume address wrong");
  a_slot_flag: assert property (l2_take |=>
    second_level_delay_slot_flag == $past(l2exc.in_delay_slot)) else $error("slot flag wrong");
  a_resume_hold: assert property (!l2exc.take && !(move.wr && move.num == CDP_REG_RESUME)
    |=> $stable(second_level_resume_address)) else $error("resume address moved");
  a_tag_load: assert property (tag_load.load |=> cache_tag_stage_low == $past(tag_load.lo)
    && cache_tag_stage_high == $past(tag_load.hi)) else $error("tag load lost");
  a_tag_hold: assert property (!tag_load.load && !move.wr |=> $stable(cache_tag_stage_low)
    && $stable(cache_tag_stage_high)) else $error("tag stage moved");
  a_brk_ctl_write: assert property (move.wr && move.num == CDP_REG_BRK && move.sub == CDP_BRK_CTRL
    |=> breakpoint_control == $past(move.wdata)) else $error("breakpoint control write lost");
  a_badpa_read: assert property (move.num == CDP_REG_BADPA |-> move_rdata == badpa_reg)
    else $error("bus error address wrong");
  a_ctl_zeros: assert property (move.num == CDP_REG_PERF && move.sub[1:0] == CDP_PERF_CTRL
    |-> (move_rdata & ~CDP_CTL_WMASK) == 32'h0) else $error("reserved control bits set");
endmodule : cdp_regs_sva
////////////////////////////////////////////////////////////////////////////////
bind cdp_regs cdp_regs_sva sva_u (.ref_clk(ref_clk), .nrst(nrst), .move(move),
  .move_rdata(move_rdata), .bus_error(bus_error), .bus_error_paddr(bus_error_paddr),
  .bus_error_mask(bus_error_mask), .l2exc(l2exc), .tag_load(tag_load),
  .second_level_delay_slot_flag(second_level_delay_slot_flag),
  .cache_tag_stage_low(cache_tag_stage_low), .cache_tag_stage_high(cache_tag_stage_high),
  .breakpoint_control(breakpoint_control),
  .second_level_resume_address(second_level_resume_address));

// File: testbench/cdp_regs_tb.sv
// self-checking bench for cdp_regs
// assumes the checker is bound from its own file
`timescale 1ns/1ns
module cdp_regs_tb
  import cdp_pkg::*;
;
  logic ref_clk = 1'b0, nrst = 1'b0, bus_error = 1'b0, bus_error_mask = 1'b0, fl_exc = 1'b0;
  logic [31:0] bus_error_paddr = 32'h0, move_rdata, tlo, thi, bp_ctl, resume;
  logic [1:0] cpu_mode = CDP_MODE_KERNEL;
  logic [15:0] ev0 = 16'h0, ev1 = 16'h0;
  logic slot_flag, exc_req;
  cdp_move_s move = '0;
  cdp_l2exc_s l2exc = '0;
  cdp_tagload_s tag_load = '0;
  int fail_count = 0, n_checks = 0, cycles = 0;
  cdp_regs dut_u (.ref_clk(ref_clk), .nrst(nrst), .move(move), .move_rdata(move_rdata),
    .bus_error(bus_error), .bus_error_paddr(bus_error_paddr), .bus_error_mask(bus_error_mask),
    .cpu_mode(cpu_mode), .first_level_exception_flag(fl_exc), .counter_zero_events(ev0),
    .counter_one_events(ev1), .l2exc(l2exc), .tag_load(tag_load),
    .second_level_delay_slot_flag(slot_flag), .counter_exception_req(exc_req),
    .cache_tag_stage_low(tlo), .cache_tag_stage_high(thi), .breakpoint_control(bp_ctl),
    .second_level_resume_address(resume));
  always #25 ref_clk = ~ref_clk;
  task report_and_stop();
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [4:0] n, input logic [2:0] s, input logic [31:0] d);
    @(negedge ref_clk);
    move = '{1'b1, n, s, d};
    @(negedge ref_clk);
    move.wr = 1'b0;
  endtask : wr
  task rd(input logic [4:0] n, input logic [2:0] s, input logic [31:0] e);
    @(negedge ref_clk);
    move.num = n;
    move.sub = s;
    #1 chk(move_rdata, e);
  endtask : rd
  task ev(input logic [15:0] z, input logic [15:0] o);
    @(negedge ref_clk);
    ev0 = z;
    ev1 = o;
    @(negedge ref_clk);
    ev0 = 16'h0;
    ev1 = 16'h0;
  endtask : ev
  // mode enables ordered user, supervisor, kernel, exception level
  function automatic logic [31:0] ctl(logic g, logic [4:0] e1, e0, logic [3:0] m1, m0);
    return {g, 11'h0, e1, m1, 1'b0, e0, m0, 1'b0};
  endfunction : ctl
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  initial
  begin
    logic [31:0] d, e;
    d = $urandom(92337);
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom;
      if (i != 1) wr(CDP_REG_BRK, 3'(i), d);
      if (i != 1) rd(CDP_REG_BRK, 3'(i), d);
      if (i == 0) chk(bp_ctl, d);
    end
    d = $urandom;
    wr(CDP_REG_PERF, 3'(CDP_PERF_CTRL), d);
    rd(CDP_REG_PERF, 3'(CDP_PERF_CTRL), d & CDP_CTL_WMASK);
    wr(CDP_REG_PERF, 3'(CDP_PERF_CNT1), d);
    rd(CDP_REG_PERF, 3'(CDP_PERF_CNT1), d);
    wr(CDP_REG_PERF, 3'(CDP_PERF_CNT0), 32'h7FFFFFFE);
    wr(CDP_REG_PERF, 3'(CDP_PERF_CTRL), ctl(1, CDP_EV_NONE, CDP_EV_CYCLE, 4'hF, 4'h2));
    ev(16'h0002, 16'hFFFF);
    rd(CDP_REG_PERF, 3'(CDP_PERF_CNT0), 32'h7FFFFFFF);
    rd(CDP_REG_PERF, 3'(CDP_PERF_CNT1), d);
    cpu_mode = CDP_MODE_USER;
    ev(16'h0002, 16'h0);
    cpu_mode = CDP_MODE_KERNEL;
    fl_exc = 1'b1;
    ev(16'h0002, 16'h0);
    fl_exc = 1'b0;
    rd(CDP_REG_PERF, 3'(CDP_PERF_CNT0), 32'h7FFFFFFF);
    ev(16'h0002, 16'h0);
    e = {31'h0, exc_req};
    @(negedge ref_clk);
    chk(e, 32'h1);
    chk({31'h0, exc_req}, 32'h0);
    rd(CDP_REG_PERF, 3'(CDP_PERF_CNT0), 32'h80000000);
    wr(CDP_REG_PERF, 3'(CDP_PERF_CNT1), 32'h0);
    wr(CDP_REG_PERF, 3'(CDP_PERF_CTRL), ctl(0, 5'h03, CDP_EV_CYCLE, 4'h8, 4'hF));
    cpu_mode = CDP_MODE_USER;
    ev(16'hFFFF, 16'h0008);
    rd(CDP_REG_PERF, 3'(CDP_PERF_CNT1), 32'h0);
    wr(CDP_REG_PERF, 3'(CDP_PERF_CTRL), ctl(1, 5'h03, CDP_EV_NONE, 4'h8, 4'hF));
    ev(16'hFFFF, 16'h0008);
    rd(CDP_REG_PERF, 3'(CDP_PERF_CNT1), 32'h1);
    rd(CDP_REG_PERF, 3'(CDP_PERF_CNT0), 32'h80000000);
    e = 32'h0;
    for (int i = 0; i < 2; i++)
    begin
      d = $urandom;
      @(negedge ref_clk);
      bus_error_mask = 1'(i);
      bus_error = 1'b1;
      bus_error_paddr = d;
      @(negedge ref_clk);
      bus_error = 1'b0;
      if (i == 0) e = d & CDP_BADPA_MASK;
      rd(CDP_REG_BADPA, 3'h0, e);
    end
    wr(CDP_REG_BADPA, 3'h0, 32'hFFFFFFFF);
    rd(CDP_REG_BADPA, 3'h0, e);
    wr(CDP_REG_STAGE_LO, 3'h0, d);
    rd(CDP_REG_STAGE_LO, 3'h0, d);
    @(negedge ref_clk);
    tag_load = '{1'b1, ~d, d};
    @(negedge ref_clk);
    tag_load.load = 1'b0;
    chk(tlo, ~d);
    chk(thi, d);
    for (int i = 0; i < 2; i++)
    begin
      d = $urandom;
      @(negedge ref_clk);
      l2exc = '{1'b1, 1'(i), d, ~d};
      @(negedge ref_clk);
      l2exc.take = 1'b0;
      chk(resume, (i == 1) ? ~d : d);
      chk({31'h0, slot_flag}, 32'(i));
    end
    report_and_stop();
  end
endmodule : cdp_regs_tb
